// ### rtl/pafo_override.sv
// pafo_override: alternate-function override logic for the eight port A pins.
// assumes: port registers and peripherals share clk_i; pad inputs are asynchronous
// and are synchronised here; all pin-facing outputs are registered (one cycle late).

// Contract
// - internal reference routed out, pin driver off
// - external reference pin: pull-up, driver off
// - SPI slave forces select pin input
// - SPI master: select direction from port
// - clock pin: slave input, master port direction
// - MOSI pin: slave input, master port direction
// - USI data out replaces bit 2 value
// - MISO pin: master input, slave port direction
// - UART transmitter forces bit 1 output
// - LIN transmit drives bit 1, pull-up off
// - UART receiver forces bit 0 input
// - LIN receiver forces bit 0 input
// - capture pin feeds timer1 capture logic
// - interrupt-one pin feeds detector, input enabled
// - value override replaces port output bit
// - input-enable override beats processor state
// - port pull-up disable ORed with global
module pafo_override #(
   parameter int unsigned N = pafo_pkg::PIN_COUNT
) (
   input  wire logic         clk_i,                        // system clock, 40 MHz
   input  wire logic         rst_n_i,                      // async reset, active low
   input  wire logic [N-1:0] pin_in_i,                     // pad levels, asynchronous
   output logic      [N-1:0] pin_out_o,                    // pad output value
   output logic      [N-1:0] pin_oe_o,                     // pad driver enable, high drives
   output logic      [N-1:0] pin_pullup_o,                 // pad pull-up enable
   output logic      [N-1:0] pin_input_enable_o,           // digital input buffer enable
   input  wire logic [N-1:0] porta_output_i,               // port output register
   input  wire logic [N-1:0] porta_direction_i,            // port direction register
   input  wire logic         global_pullup_disable_i,      // global pull-up disable
   input  wire logic         porta_pullup_disable_i,       // port-wise pull-up disable
   input  wire logic         mcu_input_enable_i,           // input enable from sleep state
   input  wire logic         spi_enable_bit_i,             // SPI enabled
   input  wire logic         spi_master_select_i,          // SPI is master
   input  wire logic         spi_sck_out_i,                // SPI master clock out
   input  wire logic         spi_mosi_out_i,               // SPI master data out
   input  wire logic         spi_miso_out_i,               // SPI slave data out
   input  wire logic         serial_if_three_wire_i,       // USI in three-wire mode
   input  wire logic         serial_if_pin_position_i,     // USI mapped onto port A
   input  wire logic         serial_if_data_out_i,         // USI data output
   input  wire logic         timer0_compare_a_enable_i,    // compare A output enabled
   input  wire logic         timer0_compare_a_output_i,    // compare A output level
   input  wire logic         uart_tx_enable_i,             // UART transmitter enabled
   input  wire logic         uart_tx_data_i,               // UART transmit level
   input  wire logic         uart_rx_enable_i,             // UART receiver enabled
   input  wire logic         lin_tx_enable_i,              // LIN transmitter enabled
   input  wire logic         lin_transmit_pin_i,           // LIN transmit level
   input  wire logic         lin_rx_enable_i,              // LIN receiver enabled
   input  wire logic         reference_output_enable_i,    // reference output enable
   input  wire logic         adc_internal_ref_i,           // ADC uses 2.56V or 1.1V reference
   input  wire logic         external_reference_input_i,   // pin used as external ref or bypass
   input  wire logic [N-1:0] analog_digital_disable_i,     // per-pin digital input disable
   input  wire logic         pin_change_group0_enable_i,   // pin-change group enable
   input  wire logic [N-1:0] pin_change_mask_i,            // pin-change mask
   input  wire logic         external_interrupt_one_en_i,  // interrupt one enabled
   output logic      [N-1:0] digital_in_o,                 // gated synchronised pin inputs
   output logic              reference_output_pin_function_o, // reference switched to pin
   output logic              spi_slave_select_n_o,         // SPI slave select, active low
   output logic              timer1_capture_input_o,       // capture trigger input
   output logic              external_interrupt_one_o      // interrupt one input
);
   // ------------------------------------------------------------------------
   // pad input synchroniser
   // ------------------------------------------------------------------------
   logic [N-1:0] sync1_reg, sync2_reg;
   logic [N-1:0] sync1_next, sync2_next;

   always_comb begin
      sync1_next = pin_in_i;
      sync2_next = sync1_reg;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_reg <= pafo_pkg::PINS_RESET;
         sync2_reg <= pafo_pkg::PINS_RESET;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
      end
   end

   // ------------------------------------------------------------------------
   // override computation
   // ------------------------------------------------------------------------
   logic [N-1:0] direction_override_enable, direction_override_value;
   logic [N-1:0] port_value_override_enable, port_value_override_value;
   logic [N-1:0] pullup_override_enable, pullup_override_value;
   logic [N-1:0] input_enable_override_enable, input_enable_override_value;
   logic [N-1:0] dir_eff, val_eff, pullup_eff, ie_eff;
   logic         pud_eff, spi_master, spi_slave, ref_out, usi3;

   always_comb begin
      direction_override_enable    = '0;
      direction_override_value     = '0;
      port_value_override_enable   = '0;
      port_value_override_value    = '0;
      pullup_override_enable       = '0;
      pullup_override_value        = '0;
      pud_eff    = global_pullup_disable_i | porta_pullup_disable_i;
      spi_master = spi_enable_bit_i & spi_master_select_i;
      spi_slave  = spi_enable_bit_i & ~spi_master_select_i;
      usi3       = serial_if_three_wire_i & serial_if_pin_position_i;
      ref_out    = reference_output_enable_i & adc_internal_ref_i;
      // bit 7: analog reference use shuts off driver and pull-up
      if (ref_out || external_reference_input_i) begin
         direction_override_enable[pafo_pkg::BIT_REFERENCE] = 1'b1;
         pullup_override_enable[pafo_pkg::BIT_REFERENCE]    = 1'b1;
      end
      // bits 6..4: slave forces input, master leaves the direction bit in charge
      if (spi_slave) begin
         direction_override_enable[pafo_pkg::BIT_SPI_SS]   = 1'b1;
         direction_override_enable[pafo_pkg::BIT_SPI_SCK]  = 1'b1;
         direction_override_enable[pafo_pkg::BIT_SPI_MOSI] = 1'b1;
      end
      if (spi_master) begin
         port_value_override_enable[pafo_pkg::BIT_SPI_SCK]  = 1'b1;
         port_value_override_value[pafo_pkg::BIT_SPI_SCK]   = spi_sck_out_i;
         port_value_override_enable[pafo_pkg::BIT_SPI_MOSI] = 1'b1;
         port_value_override_value[pafo_pkg::BIT_SPI_MOSI]  = spi_mosi_out_i;
      end
      // bit 2: SPI first, then USI data out, then timer compare
      if (spi_master) begin
         direction_override_enable[pafo_pkg::BIT_SPI_MISO] = 1'b1;
      end else if (spi_slave) begin
         port_value_override_enable[pafo_pkg::BIT_SPI_MISO] = 1'b1;
         port_value_override_value[pafo_pkg::BIT_SPI_MISO]  = spi_miso_out_i;
      end else if (usi3) begin
         port_value_override_enable[pafo_pkg::BIT_SPI_MISO] = 1'b1;
         port_value_override_value[pafo_pkg::BIT_SPI_MISO]  = serial_if_data_out_i;
      end else if (timer0_compare_a_enable_i) begin
         // the pin only shows compare output once software set its direction bit
         port_value_override_enable[pafo_pkg::BIT_SPI_MISO] = 1'b1;
         port_value_override_value[pafo_pkg::BIT_SPI_MISO]  = timer0_compare_a_output_i;
      end
      // bit 1: LIN transmit outranks UART transmit
      if (lin_tx_enable_i || uart_tx_enable_i) begin
         direction_override_enable[pafo_pkg::BIT_UART_TX]  = 1'b1;
         direction_override_value[pafo_pkg::BIT_UART_TX]   = 1'b1;
         port_value_override_enable[pafo_pkg::BIT_UART_TX] = 1'b1;
         port_value_override_value[pafo_pkg::BIT_UART_TX]  =
            lin_tx_enable_i ? lin_transmit_pin_i : uart_tx_data_i;
      end
      if (lin_tx_enable_i) begin
         pullup_override_enable[pafo_pkg::BIT_UART_TX] = 1'b1;
      end
      // bit 0: either receiver forces input, pull-up left to the port bit
      if (uart_rx_enable_i || lin_rx_enable_i) begin
         direction_override_enable[pafo_pkg::BIT_UART_RX] = 1'b1;
      end
      // digital input enable overrides
      input_enable_override_value = pin_change_mask_i & {N{pin_change_group0_enable_i}};
      input_enable_override_value[pafo_pkg::BIT_EXT_EXTERNAL_INTERRUPT_ONE] =
         input_enable_override_value[pafo_pkg::BIT_EXT_EXTERNAL_INTERRUPT_ONE] | external_interrupt_one_en_i;
      input_enable_override_enable = analog_digital_disable_i | input_enable_override_value;
      // effective pad controls
      for (int i = 0; i < N; i++) begin
         dir_eff[i] = direction_override_enable[i] ? direction_override_value[i]
                                                   : porta_direction_i[i];
         val_eff[i] = port_value_override_enable[i] ? port_value_override_value[i]
                                                    : porta_output_i[i];
         // forced inputs other than bit 7 keep pull-up control through the port bit
         pullup_eff[i] = pullup_override_enable[i] ? pullup_override_value[i]
                       : (~dir_eff[i] & porta_output_i[i] & ~pud_eff);
         ie_eff[i] = input_enable_override_enable[i] ? input_enable_override_value[i]
                                                     : mcu_input_enable_i;
      end
   end

   // ------------------------------------------------------------------------
   // registered pad and peripheral outputs
   // ------------------------------------------------------------------------
   logic [N-1:0] out_reg, oe_reg, pu_reg, ie_reg, din_reg;
   logic [N-1:0] din_next;
   logic         ref_reg;

   always_comb begin
      din_next = sync2_reg & ie_eff;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_reg <= pafo_pkg::PINS_RESET;
         oe_reg  <= pafo_pkg::PINS_RESET;
         pu_reg  <= pafo_pkg::PINS_RESET;
         ie_reg  <= pafo_pkg::PINS_RESET;
         din_reg <= pafo_pkg::PINS_RESET;
         ref_reg <= pafo_pkg::BIT_RESET;
      end else begin
         out_reg <= val_eff;
         oe_reg  <= dir_eff;
         pu_reg  <= pullup_eff;
         ie_reg  <= ie_eff;
         din_reg <= din_next;
         ref_reg <= ref_out;
      end
   end

   assign pin_out_o                       = out_reg;
   assign pin_oe_o                        = oe_reg;
   assign pin_pullup_o                    = pu_reg;
   assign pin_input_enable_o              = ie_reg;
   assign digital_in_o                    = din_reg;
   assign reference_output_pin_function_o = ref_reg;
   // select reads high while idle so a disabled input never activates the slave
   assign spi_slave_select_n_o            = din_reg[pafo_pkg::BIT_SPI_SS]
                                            | ~ie_reg[pafo_pkg::BIT_SPI_SS];
   assign timer1_capture_input_o          = din_reg[pafo_pkg::BIT_SPI_MOSI];
   assign external_interrupt_one_o        = din_reg[pafo_pkg::BIT_EXT_EXTERNAL_INTERRUPT_ONE];

   // ------------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence capture_pin_high_s;
      (pin_in_i[pafo_pkg::BIT_SPI_MOSI] && ie_eff[pafo_pkg::BIT_SPI_MOSI]) [*3];
   endsequence

   a_ref_driver_off: assert property (ref_out |=> !pin_oe_o[7] && !pin_pullup_o[7]
      && reference_output_pin_function_o) else $error("reference pin not released");
   a_ext_ref_off: assert property (external_reference_input_i |=> !pin_oe_o[7]
      && !pin_pullup_o[7]) else $error("external reference pin driven");
   a_ss_slave_input: assert property (spi_slave |=> !pin_oe_o[6])
      else $error("select pin driven in slave mode");
   a_ss_master_dir: assert property (spi_master
      |=> pin_oe_o[6] == $past(porta_direction_i[6]))
      else $error("select pin direction wrong in master mode");
   a_sck_mosi_slave: assert property (spi_slave |=> !pin_oe_o[5] && !pin_oe_o[4]
      && pin_pullup_o[4] == $past(porta_output_i[4] && !pud_eff))
      else $error("SPI slave pins not forced input");
   a_mosi_master_val: assert property (spi_master
      |=> pin_out_o[4] == $past(spi_mosi_out_i))
      else $error("MOSI value not from SPI");
   a_miso_master_in: assert property (spi_master |=> !pin_oe_o[2])
      else $error("MISO driven in master mode");
   a_usi_data_out: assert property (usi3 && !spi_enable_bit_i
      |=> pin_out_o[2] == $past(serial_if_data_out_i)) else $error("USI data lost");
   a_lin_tx_drive: assert property (lin_tx_enable_i
      |=> pin_oe_o[1] && !pin_pullup_o[1]
      && pin_out_o[1] == $past(lin_transmit_pin_i)) else $error("LIN transmit wrong");
   a_uart_tx_drive: assert property (uart_tx_enable_i |=> pin_oe_o[1])
      else $error("UART transmit pin not output");
   a_rx_forced_in: assert property (uart_rx_enable_i || lin_rx_enable_i
      |=> !pin_oe_o[0] && pin_pullup_o[0] == $past(porta_output_i[0] && !pud_eff))
      else $error("receive pin not input");
   a_capture_path: assert property (capture_pin_high_s |=> timer1_capture_input_o)
      else $error("capture input not delivered");
   a_external_interrupt_one_enabled: assert property (external_interrupt_one_en_i
      |=> pin_input_enable_o[3])
      else $error("interrupt one input disabled");
   a_pullup_disable: assert property (global_pullup_disable_i
      || porta_pullup_disable_i
      |=> pin_pullup_o == '0) else $error("pull-up active while disabled");
   a_ie_override: assert property (analog_digital_disable_i[5]
      && !pin_change_mask_i[5]
      |=> !pin_input_enable_o[5]) else $error("input enable override ignored");
endmodule // pafo_override

// ### rtl/pafo_pkg.sv
// pafo_pkg: pin positions and widths for the port A override block.
// assumes: one system clock; all users write pafo_pkg::name.
package pafo_pkg;
   localparam int unsigned PIN_COUNT      = 8;
   localparam int unsigned SYNC_STAGES    = 2;
   // --------------------------------------------------------------------
   // pin positions within port A
   // --------------------------------------------------------------------
   localparam int unsigned BIT_UART_RX    = 0;
   localparam int unsigned BIT_UART_TX    = 1;
   localparam int unsigned BIT_SPI_MISO   = 2;
   localparam int unsigned BIT_EXT_EXTERNAL_INTERRUPT_ONE   = 3;
   localparam int unsigned BIT_SPI_MOSI   = 4;
   localparam int unsigned BIT_SPI_SCK    = 5;
   localparam int unsigned BIT_SPI_SS     = 6;
   localparam int unsigned BIT_REFERENCE  = 7;
   // --------------------------------------------------------------------
   // reset values of the registered outputs
   // --------------------------------------------------------------------
   localparam logic [PIN_COUNT-1:0] PINS_RESET = 8'h00;
   localparam logic                 BIT_RESET  = 1'h0;
   localparam logic                 SS_RESET_N = 1'h1;
endpackage : pafo_pkg

// ### verif/pafo_periph_model.sv
// pafo_periph_model: pad load and outside sources facing the port A override block.
// assumes: the bench sets the outside sources at the falling edge of the clock.
module pafo_periph_model (
   input  wire logic       clk_i,        // system clock
   input  wire logic [7:0] pin_out_i,    // pad value from the block
   input  wire logic [7:0] pin_oe_i,     // pad driver enable from the block
   input  wire logic [7:0] pin_pullup_i, // pull-up enable from the block
   input  wire logic [7:0] ext_drive_i,  // outside source drives the pad
   input  wire logic [7:0] ext_level_i,  // level of the outside source
   output logic      [7:0] pin_in_o      // resolved pad level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] float_q = 8'h55;
   // floating pads wander so a stale level cannot pass for a driven one
   always @(posedge clk_i) float_q <= ~float_q;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe_i[i]) pin_in_o[i] = pin_out_i[i];
         else if (ext_drive_i[i]) pin_in_o[i] = ext_level_i[i];
         else if (pin_pullup_i[i]) pin_in_o[i] = 1'b1;
         else pin_in_o[i] = float_q[i];
      end
   end
endmodule // pafo_periph_model

// ### verif/test_pafo_override.sv
// test_pafo_override: scenario bench for the port A override block.
// assumes: pad controls land one edge after the inputs; pad inputs take three edges.
module test_pafo_override;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------------
   // signals
   // ------------------------------------------------------------------
   logic       clk_i = 1'b0;
   logic       rst_n_i;
   logic [7:0] port, dir, adc_dis, pc_mask, ext_drv, ext_lvl, pin_in;
   logic [7:0] pin_out, pin_oe, pin_pu, pin_ie, din;
   logic       gpud, ppud, mcu_ie, spi_enable_bit, spi_master_select, sck, mosi, miso, usi3, serial_if_pin_position, usido;
   logic       t0en, t0out, utxen, utxd, urxen, ltxen, ltx, lrxen, refen, adcint, extref;
   logic       pcie, int1en, ref_fn, ss_n, cap, external_interrupt_one;
   int         mismatches = 0;
   int         n_checks = 0;
   always #12.5 clk_i = ~clk_i;
   pafo_override u_pafo_override (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .pin_in_i(pin_in), .pin_out_o(pin_out),
      .pin_oe_o(pin_oe), .pin_pullup_o(pin_pu), .pin_input_enable_o(pin_ie),
      .porta_output_i(port), .porta_direction_i(dir), .global_pullup_disable_i(gpud),
      .porta_pullup_disable_i(ppud), .mcu_input_enable_i(mcu_ie), .spi_enable_bit_i(spi_enable_bit),
      .spi_master_select_i(spi_master_select), .spi_sck_out_i(sck), .spi_mosi_out_i(mosi),
      .spi_miso_out_i(miso), .serial_if_three_wire_i(usi3), .serial_if_pin_position_i(serial_if_pin_position),
      .serial_if_data_out_i(usido), .timer0_compare_a_enable_i(t0en),
      .timer0_compare_a_output_i(t0out), .uart_tx_enable_i(utxen), .uart_tx_data_i(utxd),
      .uart_rx_enable_i(urxen), .lin_tx_enable_i(ltxen), .lin_transmit_pin_i(ltx),
      .lin_rx_enable_i(lrxen), .reference_output_enable_i(refen), .adc_internal_ref_i(adcint),
      .external_reference_input_i(extref), .analog_digital_disable_i(adc_dis),
      .pin_change_group0_enable_i(pcie), .pin_change_mask_i(pc_mask),
      .external_interrupt_one_en_i(int1en), .digital_in_o(din),
      .reference_output_pin_function_o(ref_fn), .spi_slave_select_n_o(ss_n),
      .timer1_capture_input_o(cap), .external_interrupt_one_o(external_interrupt_one));
   pafo_periph_model u_pafo_periph_model (
      .clk_i(clk_i), .pin_out_i(pin_out), .pin_oe_i(pin_oe), .pin_pullup_i(pin_pu),
      .ext_drive_i(ext_drv), .ext_level_i(ext_lvl), .pin_in_o(pin_in));
   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input logic [7:0] mask);
      n_checks++;
      if ((seen & mask) !== (exp & mask)) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h mask %h", $time, seen, exp, mask);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic idle();
      {gpud, ppud, spi_enable_bit, spi_master_select, sck, mosi, miso, usi3, serial_if_pin_position, usido, t0en, t0out} = '0;
      {utxen, utxd, urxen, ltxen, ltx, lrxen, refen, adcint, extref, pcie, int1en} = '0;
      {port, dir, adc_dis, pc_mask, ext_drv, ext_lvl} = '0;
      mcu_ie = 1'b1;
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_spi();
      idle();
      {spi_enable_bit, dir, port} = {1'b1, 8'hFF, 8'h74};
      step(1);
      chk(pin_oe, 8'h00, 8'h40);
      chk(pin_oe, 8'h00, 8'h20);
      chk(pin_oe, 8'h00, 8'h10);
      chk(pin_pu, 8'h70, 8'h70);
      chk(pin_oe & ~pin_out, 8'h04, 8'h04);
      {ext_drv, ext_lvl} = {8'h40, 8'h00};
      step(3);
      chk({7'h00, ss_n}, 8'h00, 8'h01);
      ext_lvl = 8'h40;
      step(3);
      chk({7'h00, ss_n}, 8'h01, 8'h01);
      ext_drv = 8'h00;
      ppud = 1'b1;
      step(1);
      chk(pin_pu, 8'h00, 8'h70);
      {ppud, gpud} = 2'b01;
      step(1);
      chk(pin_pu, 8'h00, 8'h70);
      {gpud, spi_master_select, sck, mosi, dir} = {4'b0110, 8'h74};
      step(1);
      chk(pin_oe, 8'h70, 8'h74);
      chk(pin_pu, 8'h04, 8'h04);
      chk(pin_out, 8'h60, 8'h70);
      dir = 8'h04;
      step(1);
      chk(pin_oe, 8'h00, 8'h74);
      chk(pin_pu, 8'h74, 8'h74);
      $display("spi test done");
   endtask
   task automatic t_bit2();
      idle();
      // direction set before any alternate output is expected on bit 2
      {usi3, serial_if_pin_position, usido, t0en, dir} = {4'b1111, 8'h04};
      step(1);
      chk(pin_oe & pin_out, 8'h04, 8'h04);
      {dir, port} = {8'h00, 8'h04};
      step(1);
      chk(pin_oe, 8'h00, 8'h04);
      chk(pin_pu, 8'h04, 8'h04);
      {spi_enable_bit, dir} = {1'b1, 8'h04};
      step(1);
      chk(pin_out, 8'h00, 8'h04);
      {spi_enable_bit, usi3} = 2'b00;
      step(1);
      chk(pin_out, 8'h00, 8'h04);
      $display("bit2 test done");
   endtask
   task automatic t_uart_lin();
      idle();
      {utxen, utxd, urxen, dir, port} = {3'b111, 8'h01, 8'h03};
      step(1);
      chk(pin_oe & pin_out, 8'h02, 8'h02);
      chk(pin_oe, 8'h00, 8'h01);
      chk(pin_pu, 8'h01, 8'h01);
      {ltxen, ltx, urxen, lrxen, dir} = {4'b1001, 8'h03};
      step(1);
      chk(pin_oe, 8'h02, 8'h03);
      chk(pin_out | pin_pu, 8'h00, 8'h02);
      chk(pin_pu, 8'h01, 8'h01);
      $display("uart lin test done");
   endtask
   task automatic t_reference();
      idle();
      {refen, adcint, dir, port} = {2'b11, 8'h80, 8'h80};
      step(1);
      chk({7'h00, ref_fn}, 8'h01, 8'h01);
      chk(pin_oe | pin_pu, 8'h00, 8'h80);
      adcint = 1'b0;
      step(1);
      chk({7'h00, ref_fn}, 8'h00, 8'h01);
      chk(pin_oe, 8'h80, 8'h80);
      {extref, dir} = {1'b1, 8'h00};
      step(1);
      chk(pin_oe | pin_pu, 8'h00, 8'h80);
      $display("reference test done");
   endtask
   task automatic t_inputs();
      idle();
      // data-in pin left as input by software while the serial interface listens
      {usi3, serial_if_pin_position, ext_drv} = {2'b11, 8'h18};
      step(4);
      ext_lvl = 8'h18;
      step(2);
      chk({7'h00, cap}, 8'h00, 8'h01);
      step(1);
      chk({7'h00, cap}, 8'h01, 8'h01);
      chk(din, 8'h18, 8'h18);
      {mcu_ie, int1en, pcie, pc_mask, adc_dis} = {3'b011, 8'h10, 8'h20};
      step(1);
      chk(pin_ie, 8'h18, 8'hFF);
      step(4);
      chk({7'h00, external_interrupt_one}, 8'h01, 8'h01);
      chk(din, 8'h18, 8'hFF);
      mcu_ie = 1'b1;
      step(1);
      chk(pin_ie, 8'hDF, 8'hFF);
      $display("input test done");
   endtask
   // ------------------------------------------------------------------
   // main sequence and hang guard
   // ------------------------------------------------------------------
   initial begin
      idle();
      rst_n_i = 1'b0;
      step(6);
      chk(pin_oe | pin_pu | pin_out, 8'h00, 8'hFF);
      chk({7'h00, ss_n}, 8'h01, 8'h01);
      rst_n_i = 1'b1;
      t_spi();
      t_bit2();
      t_uart_lin();
      t_reference();
      t_inputs();
      give_verdict();
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      mismatches++;
      give_verdict();
   end
endmodule // test_pafo_override
